// *** shared/qsp_pkg.sv ***
// Shared constants and types of the two-word burst SRAM port
package qsp_pkg;
   // Array shape of the 18-bit variant
   localparam int ADDR_W      = 21;        // Burst address on the shared bus
   localparam int DATA_W      = 18;        // Word width
   localparam int LANE_W      = 9;         // Bits per write lane
   localparam int LANES       = 2;         // Write lanes per word
   localparam int DEPTH       = 4194304;   // Words in the array
   localparam int BURST_LEN   = 2;         // Words per command, fixed
   // Delay loop settling, in input clock cycles
   localparam int LOCK_CYCLES = 2048;
   localparam int LOCK_W      = 12;
   // Input clock edges before the output clock strap is caught
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // Reset values
   localparam logic [DATA_W-1:0] WORD_RST = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
   // Output port state
   typedef enum logic {
      QSP_OUT_IDLE  = 1'b0,
      QSP_OUT_BURST = 1'b1
   } qsp_out_state_type;
endpackage : qsp_pkg

// *** hw/qsp_sync2.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module qsp_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Level in and out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : qsp_sync2

// *** hw/qsp_lock_timer.sv ***
// Delay loop settling counter on the input clock
`timescale 1ns/1ps
module qsp_lock_timer (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Loop enable and settled flag
   input  wire logic enable_i,
   output logic      ready_o
);
   logic [qsp_pkg::LOCK_W-1:0] cnt;
   logic [qsp_pkg::LOCK_W-1:0] next_cnt;
   logic                       next_ready;

   // Count input clock edges while the loop runs
   always_comb begin
      next_cnt   = cnt;
      next_ready = ready_o;
      if (!enable_i) begin
         next_cnt   = '0;
         next_ready = 1'b0;
      end else if (cnt == qsp_pkg::LOCK_W'(qsp_pkg::LOCK_CYCLES - 1)) begin
         next_ready = 1'b1;
      end else begin
         next_cnt = cnt + qsp_pkg::LOCK_W'(1);
      end
   end

   // Register counter and flag
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt     <= '0;
         ready_o <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         ready_o <= next_ready;
      end
   end
endmodule : qsp_lock_timer

// *** hw/qsp_sram_port.sv ***
// Two-word burst SRAM port with separate input and output data buses
// Function
// (RL1) Write data on both input edges, read on both output edges
// (RL2) Address, data, controls sampled on input clock pair
// (RL3) Output clocks both high: time reads from input
// (RL4) Echo strobe pair aligned with read data
// (RL5) Read address taken on true input edge
// (RL6) Write address taken on complementary input edge
// (RL7) Controller time-shares address bus read/write
// (RL8) Every command moves exactly two sequential words
// (RL9) Read and write in same cycle, separate ports
// (RL10) Fetch select low requests a read
// (RL11) Store request low requests a write
// (RL12) Low lane mask enables that lane's write
// (RL13) Delay loop off low disables the loop
// (RL14) Controller selects devices per side for depth
// (RL15) Array is 4,194,304 words of 18 bits
// (RL16) First read word on complementary output edge
// (RL17) Write words on true then complementary edge
// (RL18) Finish burst, deselect, then release outputs
// (RL19) Controller waits 2048 cycles after loop enable
`timescale 1ns/1ps
module qsp_sram_port (
   // System clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_i,
   // Input strobe pair
   input  wire logic                       strobe_i,
   input  wire logic                       strobe_n_i,
   // Output data timing pair
   input  wire logic                       out_clk_i,
   input  wire logic                       out_clk_n_i,
   // Commands and address
   input  wire logic                       fetch_select_n_i,
   input  wire logic                       store_request_n_i,
   input  wire logic [qsp_pkg::ADDR_W-1:0] shared_address_i,
   // Write data and lane masks
   input  wire logic [qsp_pkg::DATA_W-1:0] write_in_bus_i,
   input  wire logic [qsp_pkg::LANES-1:0]  lane_store_mask_n_i,
   // Delay loop control
   input  wire logic                       delay_loop_off_i,
   // Read data, drive enable and echo pair
   output logic      [qsp_pkg::DATA_W-1:0] read_out_bus_o,
   output logic                            read_drive_n_o,
   output logic                            returned_strobe_o,
   output logic                            returned_strobe_n_o,
   // Status on the system clock
   output logic                            dll_locked_o
);
   // Memory array
   logic [qsp_pkg::DATA_W-1:0] mem [0:qsp_pkg::DEPTH-1]; // [RL15]

   // Merge new data into old word under the active-low lane mask
   function automatic logic [qsp_pkg::DATA_W-1:0] lane_merge(
      input logic [qsp_pkg::DATA_W-1:0] old_w,
      input logic [qsp_pkg::DATA_W-1:0] new_w,
      input logic [qsp_pkg::LANES-1:0]  mask_n);
      logic [qsp_pkg::DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < qsp_pkg::LANES; i++) begin
         if (!mask_n[i]) begin
            res[i*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] = new_w[i*qsp_pkg::LANE_W +: qsp_pkg::LANE_W]; // [RL12]
         end
      end
      return res;
   endfunction : lane_merge

   // Word index of a burst beat
   function automatic logic [qsp_pkg::ADDR_W:0] beat_index(
      input logic [qsp_pkg::ADDR_W-1:0] base,
      input logic                       beat);
      return {base, beat}; // [RL8]
   endfunction : beat_index

   // Pin levels into the input clock domain
   logic [2:0] pin_sync;
   qsp_sync2 #(.WIDTH(3)) u_pin_sync (
      .clk_i   (strobe_i),
      .rst_i   (rst_i),
      .async_i ({delay_loop_off_i, out_clk_n_i, out_clk_i}),
      .sync_o  (pin_sync)
   );

   // Delay loop runs while its control pin is high
   logic dll_ready;
   qsp_lock_timer u_lock (
      .clk_i    (strobe_i),
      .rst_i    (rst_i),
      .enable_i (pin_sync[2]), // [RL13]
      .ready_o  (dll_ready)
   );

   // Settled flag into the system domain
   qsp_sync2 #(.WIDTH(1)) u_lock_sync (
      .clk_i   (sys_clk_i),
      .rst_i   (rst_i),
      .async_i (dll_ready),
      .sync_o  (dll_locked_o)
   );

   // Output clock strap caught once after reset
   logic [1:0] strap_cnt;
   logic [1:0] next_strap_cnt;
   logic       single_mode;
   logic       next_single_mode;

   always_comb begin
      next_strap_cnt   = strap_cnt;
      next_single_mode = single_mode;
      if (strap_cnt != qsp_pkg::STRAP_WAIT) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (next_strap_cnt == qsp_pkg::STRAP_WAIT) begin
            next_single_mode = pin_sync[0] & pin_sync[1]; // [RL3]
         end
      end
   end

   always_ff @(posedge strobe_i or posedge rst_i) begin
      if (rst_i) begin
         strap_cnt   <= 2'h0;
         single_mode <= 1'b0;
      end else begin
         strap_cnt   <= next_strap_cnt;
         single_mode <= next_single_mode;
      end
   end

   // Commands, read address and first write beat on the true input edge
   logic                       rd_req;
   logic [qsp_pkg::ADDR_W-1:0] rd_addr;
   logic                       wr_req;
   logic [qsp_pkg::DATA_W-1:0] wr_d0;
   logic [qsp_pkg::LANES-1:0]  wr_m0;
   logic                       next_rd_req;
   logic [qsp_pkg::ADDR_W-1:0] next_rd_addr;
   logic                       next_wr_req;
   logic [qsp_pkg::DATA_W-1:0] next_wr_d0;
   logic [qsp_pkg::LANES-1:0]  next_wr_m0;

   always_comb begin
      next_rd_req  = !fetch_select_n_i; // [RL10] [RL2]
      next_rd_addr = fetch_select_n_i ? rd_addr : shared_address_i; // [RL5]
      next_wr_req  = !store_request_n_i; // [RL11]
      next_wr_d0   = write_in_bus_i; // [RL17] [RL1]
      next_wr_m0   = lane_store_mask_n_i;
   end

   always_ff @(posedge strobe_i or posedge rst_i) begin
      if (rst_i) begin
         rd_req  <= 1'b0;
         rd_addr <= qsp_pkg::ADDR_RST;
         wr_req  <= 1'b0;
         wr_d0   <= qsp_pkg::WORD_RST;
         wr_m0   <= '1;
      end else begin
         rd_req  <= next_rd_req;
         rd_addr <= next_rd_addr;
         wr_req  <= next_wr_req;
         wr_d0   <= next_wr_d0;
         wr_m0   <= next_wr_m0;
      end
   end

   // Write address and second beat on the complementary input edge
   logic                       wr_go;
   logic [qsp_pkg::ADDR_W-1:0] wr_addr;
   logic [qsp_pkg::DATA_W-1:0] wr_d1;
   logic [qsp_pkg::DATA_W-1:0] wr_d0_hold;
   logic [qsp_pkg::LANES-1:0]  wr_m1;
   logic [qsp_pkg::LANES-1:0]  wr_m0_hold;
   logic                       next_wr_go;
   logic [qsp_pkg::ADDR_W-1:0] next_wr_addr;
   logic [qsp_pkg::DATA_W-1:0] next_wr_d1;
   logic [qsp_pkg::DATA_W-1:0] next_wr_d0_hold;
   logic [qsp_pkg::LANES-1:0]  next_wr_m1;
   logic [qsp_pkg::LANES-1:0]  next_wr_m0_hold;

   always_comb begin
      next_wr_go      = wr_req;
      next_wr_addr    = wr_addr;
      next_wr_d1      = wr_d1;
      next_wr_d0_hold = wr_d0_hold;
      next_wr_m1      = wr_m1;
      next_wr_m0_hold = wr_m0_hold;
      if (wr_req) begin
         next_wr_addr    = shared_address_i; // [RL6]
         next_wr_d1      = write_in_bus_i; // [RL17] [RL1]
         next_wr_m1      = lane_store_mask_n_i;
         next_wr_d0_hold = wr_d0;
         next_wr_m0_hold = wr_m0;
      end
   end

   always_ff @(posedge strobe_n_i or posedge rst_i) begin
      if (rst_i) begin
         wr_go      <= 1'b0;
         wr_addr    <= qsp_pkg::ADDR_RST;
         wr_d1      <= qsp_pkg::WORD_RST;
         wr_d0_hold <= qsp_pkg::WORD_RST;
         wr_m1      <= '1;
         wr_m0_hold <= '1;
      end else begin
         wr_go      <= next_wr_go;
         wr_addr    <= next_wr_addr;
         wr_d1      <= next_wr_d1;
         wr_d0_hold <= next_wr_d0_hold;
         wr_m1      <= next_wr_m1;
         wr_m0_hold <= next_wr_m0_hold;
      end
   end

   // Array write of both beats, read fetch of both beats
   logic [qsp_pkg::DATA_W-1:0] rd_w0;
   logic [qsp_pkg::DATA_W-1:0] rd_w1;
   logic                       rd_tog;

   always_ff @(posedge strobe_i) begin
      if (!rst_i && wr_go) begin
         mem[beat_index(wr_addr, 1'b0)] <= lane_merge(mem[beat_index(wr_addr, 1'b0)], wr_d0_hold, wr_m0_hold); // [RL8]
         mem[beat_index(wr_addr, 1'b1)] <= lane_merge(mem[beat_index(wr_addr, 1'b1)], wr_d1, wr_m1); // [RL8]
      end
   end

   // Read side runs alongside writes on its own port
   always_ff @(posedge strobe_i or posedge rst_i) begin
      if (rst_i) begin
         rd_w0  <= qsp_pkg::WORD_RST;
         rd_w1  <= qsp_pkg::WORD_RST;
         rd_tog <= 1'b0;
      end else if (rd_req) begin
         rd_w0  <= mem[beat_index(rd_addr, 1'b0)]; // [RL9]
         rd_w1  <= mem[beat_index(rd_addr, 1'b1)];
         rd_tog <= !rd_tog;
      end
   end

   // Launch clocks: output pair, or input pair when strapped high
   logic launch_clk;
   logic launch_clk_n;
   assign launch_clk   = single_mode ? strobe_i : out_clk_i; // [RL3]
   assign launch_clk_n = single_mode ? strobe_n_i : out_clk_n_i; // [RL3]

   // First word and drive state on the complementary launch edge
   qsp_pkg::qsp_out_state_type out_state;
   qsp_pkg::qsp_out_state_type next_out_state;
   logic                       n_ack;
   logic                       n_phase;
   logic [qsp_pkg::DATA_W-1:0] q_first;
   logic [qsp_pkg::DATA_W-1:0] q_second_hold;
   logic                       next_n_ack;
   logic [qsp_pkg::DATA_W-1:0] next_q_first;
   logic [qsp_pkg::DATA_W-1:0] next_q_second_hold;

   always_comb begin
      next_n_ack         = rd_tog;
      next_q_first       = q_first;
      next_q_second_hold = q_second_hold;
      case (out_state)
         qsp_pkg::QSP_OUT_IDLE,
         qsp_pkg::QSP_OUT_BURST: begin
            if (rd_tog != n_ack) begin
               next_out_state     = qsp_pkg::QSP_OUT_BURST;
               next_q_first       = rd_w0; // [RL16] [RL1]
               next_q_second_hold = rd_w1;
            end else begin
               next_out_state = qsp_pkg::QSP_OUT_IDLE; // [RL18]
            end
         end
         default: begin
            next_out_state = qsp_pkg::QSP_OUT_IDLE;
         end
      endcase
   end

   always_ff @(posedge launch_clk_n or posedge rst_i) begin
      if (rst_i) begin
         out_state     <= qsp_pkg::QSP_OUT_IDLE;
         n_ack         <= 1'b0;
         n_phase       <= 1'b0;
         q_first       <= qsp_pkg::WORD_RST;
         q_second_hold <= qsp_pkg::WORD_RST;
      end else begin
         out_state     <= next_out_state;
         n_ack         <= next_n_ack;
         n_phase       <= !n_phase;
         q_first       <= next_q_first;
         q_second_hold <= next_q_second_hold;
      end
   end

   // Second word on the following true launch edge
   logic                       p_phase;
   logic [qsp_pkg::DATA_W-1:0] q_second;

   always_ff @(posedge launch_clk or posedge rst_i) begin
      if (rst_i) begin
         p_phase  <= 1'b0;
         q_second <= qsp_pkg::WORD_RST;
      end else begin
         p_phase  <= !p_phase;
         q_second <= q_second_hold; // [RL16] [RL1]
      end
   end

   // Double-rate outputs picked by which launch edge came last
   always_comb begin
      read_out_bus_o      = (p_phase != n_phase) ? q_first : q_second;
      returned_strobe_o   = (p_phase == n_phase); // [RL4]
      returned_strobe_n_o = (p_phase != n_phase); // [RL4]
      read_drive_n_o      = (out_state == qsp_pkg::QSP_OUT_IDLE); // [RL18]
   end
endmodule : qsp_sram_port

// *** test/qsp_checker_assertions.sv ***
// Checker of the burst SRAM port outputs
`timescale 1ns/1ps
module qsp_checker (
   // Clocks and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic strobe_i,
   input wire logic strobe_n_i,
   // Controls
   input wire logic fetch_select_n_i,
   input wire logic delay_loop_off_i,
   // Outputs watched
   input wire logic read_drive_n_o,
   input wire logic returned_strobe_o,
   input wire logic returned_strobe_n_o,
   input wire logic dll_locked_o
);
   logic [2:0]  rises;
   logic [2:0]  next_rises;
   logic [11:0] on_cnt;
   logic [11:0] next_on_cnt;
   logic        rdy;
   // Strobe rises since reset and since loop enable
   always_comb begin
      next_rises  = (rises == 3'h7) ? rises : rises + 3'h1;
      next_on_cnt = !delay_loop_off_i ? 12'h000 : (&on_cnt) ? on_cnt : on_cnt + 12'h001;
   end
   always_ff @(posedge strobe_i or posedge rst_i) begin
      if (rst_i) begin
         rises  <= 3'h0;
         on_cnt <= 12'h000;
      end else begin
         rises  <= next_rises;
         on_cnt <= next_on_cnt;
      end
   end
   // Strap settled, commands legal
   assign rdy = (rises >= 3'h6);
   drive_on_read_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      rdy && !fetch_select_n_i |-> ##2 !read_drive_n_o) else $error("read output not driven");
   drive_release_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      rdy && fetch_select_n_i |-> ##2 read_drive_n_o) else $error("read output not released");
   read_stream_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      rdy && !fetch_select_n_i ##1 !fetch_select_n_i |-> ##1 !read_drive_n_o [*2])
      else $error("drive dropped between reads");
   echo_true_a: assert property (@(posedge strobe_n_i) disable iff (rst_i)
      rdy |-> returned_strobe_o && !returned_strobe_n_o) else $error("echo wrong at complementary edge");
   echo_comp_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      rdy |-> !returned_strobe_o && returned_strobe_n_o) else $error("echo wrong at true edge");
   lock_early_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(dll_locked_o) |-> on_cnt >= 12'h800) else $error("loop ready too soon");
   lock_late_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      on_cnt >= 12'h808 |-> dll_locked_o) else $error("loop ready too late");
   loop_off_a: assert property (@(posedge strobe_i) disable iff (rst_i)
      !delay_loop_off_i [*5] |-> !dll_locked_o) else $error("loop ready while disabled");
endmodule : qsp_checker
bind qsp_sram_port qsp_checker chk (.sys_clk_i, .rst_i, .strobe_i, .strobe_n_i, .fetch_select_n_i,
   .delay_loop_off_i, .read_drive_n_o, .returned_strobe_o, .returned_strobe_n_o, .dll_locked_o);

// *** test/qsp_ctrl_model.sv ***
// Memory controller model facing the port
`timescale 1ns/1ps
module qsp_ctrl_model (
   // Strobe pair
   output logic             strobe_o,
   output logic             strobe_n_o,
   // Commands, address, write data
   output logic             fetch_n_o,
   output logic             store_n_o,
   output logic [20:0]      addr_o,
   output logic [17:0]      data_o,
   output logic [1:0]       mask_n_o,
   // Read data and echo pair
   input  wire logic [17:0] rd_bus_i,
   input  wire logic        drive_n_i,
   input  wire logic        echo_i,
   input  wire logic        echo_n_i
);
   logic [17:0] got [$];
   // Free running strobe pair, 125 ns
   initial begin
      strobe_o  = 1'b0;
      fetch_n_o = 1'b1;
      store_n_o = 1'b1;
      addr_o    = 21'h000000;
      data_o    = 18'h00000;
      mask_n_o  = 2'h3;
      #7;
      forever #62.5 strobe_o = ~strobe_o;
   end
   assign strobe_n_o = ~strobe_o;
   // One cycle: command half a cycle ahead, then write address and beat 1
   task automatic cyc(input logic rd, input logic [20:0] ra, input logic wr, input logic [20:0] wa,
                      input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
      @(posedge strobe_n_o);
      fetch_n_o <= !rd;
      store_n_o <= !wr;
      addr_o    <= rd ? ra : ~addr_o;
      data_o    <= wr ? d0 : ~data_o;
      mask_n_o  <= m0;
      @(posedge strobe_o);
      addr_o    <= wr ? wa : ~addr_o;
      data_o    <= wr ? d1 : ~data_o;
      mask_n_o  <= m1;
   endtask : cyc
   // Capture read words a quarter cycle after each echo edge
   always @(posedge echo_i or posedge echo_n_i) begin
      #31;
      if (drive_n_i === 1'b0) begin
         got.push_back(rd_bus_i);
      end
   end
endmodule : qsp_ctrl_model

// *** test/tb.sv ***
// Self-checking bench of the burst SRAM port
`timescale 1ns/1ps
module tb;
   // Design pins
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              delay_loop_off_i = 1'b1;
   logic              out_clk_i = 1'b1;
   logic              out_clk_n_i = 1'b1;
   logic              dual_clk = 1'b0;
   wire logic         strobe_i, strobe_n_i, fetch_select_n_i, store_request_n_i;
   wire logic [20:0]  shared_address_i;
   wire logic [17:0]  write_in_bus_i, read_out_bus_o;
   wire logic [1:0]   lane_store_mask_n_i;
   wire logic         read_drive_n_o, returned_strobe_o, returned_strobe_n_o, dll_locked_o;
   // Bench state; pool holds both ends of the array
   int                miscompares = 0;
   int                compares = 0;
   logic [31:0]       seed = 32'h526f657f;
   logic [31:0]       r;
   logic [20:0]       pool [4] = '{21'h000000, 21'h1fffff, 21'h0a5a5a, 21'h155555};
   logic [17:0]       mem [8];
   logic [17:0]       exp_q [$];
   always #10 sys_clk_i = ~sys_clk_i;
   // Output timing pair: tied high, or the strobe pair 20 ns late
   always @(strobe_i) begin
      out_clk_i   <= #20 (dual_clk ? strobe_i : 1'b1);
      out_clk_n_i <= #20 (dual_clk ? !strobe_i : 1'b1);
   end
   qsp_sram_port dut (.sys_clk_i, .rst_i, .strobe_i, .strobe_n_i, .out_clk_i, .out_clk_n_i,
      .fetch_select_n_i, .store_request_n_i, .shared_address_i, .write_in_bus_i,
      .lane_store_mask_n_i, .delay_loop_off_i, .read_out_bus_o, .read_drive_n_o,
      .returned_strobe_o, .returned_strobe_n_o, .dll_locked_o);
   qsp_ctrl_model ctrl (.strobe_o(strobe_i), .strobe_n_o(strobe_n_i), .fetch_n_o(fetch_select_n_i),
      .store_n_o(store_request_n_i), .addr_o(shared_address_i), .data_o(write_in_bus_i),
      .mask_n_o(lane_store_mask_n_i), .rd_bus_i(read_out_bus_o), .drive_n_i(read_drive_n_o),
      .echo_i(returned_strobe_o), .echo_n_i(returned_strobe_n_o));
   // Xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Lane merge, low mask writes the lane
   function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] m);
      return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
   endfunction : merge
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // Bounded wait for the loop to settle
   task automatic wait_lock();
      for (int i = 0; i < 2300 && dll_locked_o !== 1'b1; i++) begin
         @(posedge strobe_i);
      end
      check("lock", {17'h00000, dll_locked_o}, 18'h00001);
   endtask : wait_lock
   // One cycle with reference update
   task automatic op(input logic rd, input logic [1:0] ri, input logic wr, input logic [1:0] wi,
                     input logic [35:0] d, input logic [3:0] m);
      if (rd) begin
         exp_q.push_back(mem[{ri, 1'b0}]);
         exp_q.push_back(mem[{ri, 1'b1}]);
      end
      if (wr) begin
         mem[{wi, 1'b0}] = merge(mem[{wi, 1'b0}], d[17:0], m[1:0]);
         mem[{wi, 1'b1}] = merge(mem[{wi, 1'b1}], d[35:18], m[3:2]);
      end
      ctrl.cyc(rd, pool[ri], wr, pool[wi], d[17:0], d[35:18], m[1:0], m[3:2]);
   endtask : op
   // Idle cycles, then every captured word in order
   task automatic drain(input string name);
      repeat (4) op(1'b0, 2'h0, 1'b0, 2'h0, 36'h000000000, 4'hf);
      check("words", 18'(ctrl.got.size()), 18'(exp_q.size()));
      while (ctrl.got.size() > 0 && exp_q.size() > 0) begin
         check(name, ctrl.got.pop_front(), exp_q.pop_front());
      end
      $display("test %s done", name);
   endtask : drain
   initial begin
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      wait_lock();
      // Full writes of the pool back to back, then a fully masked write, a lane-masked write beside a read, and a read
      for (int i = 0; i < 4; i++) begin
         op(1'b0, 2'h0, 1'b1, 2'(i), 36'({rnd(), rnd()}), 4'h0);
      end
      op(1'b0, 2'h0, 1'b1, 2'h0, 36'hfffffffff, 4'hf);
      op(1'b1, 2'h0, 1'b1, 2'h1, 36'({rnd(), rnd()}), 4'h6);
      op(1'b1, 2'h1, 1'b0, 2'h0, 36'h000000000, 4'hf);
      drain("corner");
      // Random mixed traffic, same-address read and write kept apart
      for (int i = 0; i < 300; i++) begin
         r = rnd();
         op(r[0], r[2:1], r[3] && (r[2:1] != r[5:4] || !r[0]), r[5:4], 36'({rnd(), rnd()}), r[9:6]);
      end
      drain("random");
      @(posedge strobe_i);
      delay_loop_off_i <= 1'b0;
      repeat (8) @(posedge strobe_i);
      check("loop off", {17'h00000, dll_locked_o}, 18'h00000);
      delay_loop_off_i <= 1'b1;
      wait_lock();
      $display("test loop done");
      // Second reset with the output pair running: launch from that pair
      @(posedge sys_clk_i);
      rst_i    <= 1'b1;
      dual_clk <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      wait_lock();
      // Array keeps its words across reset; read them back, then read beside a write
      for (int i = 0; i < 4; i++) begin
         op(1'b1, 2'(i), 1'b0, 2'h0, 36'h000000000, 4'hf);
      end
      op(1'b1, 2'h2, 1'b1, 2'h2, 36'({rnd(), rnd()}), 4'h0);
      op(1'b1, 2'h2, 1'b0, 2'h0, 36'h000000000, 4'hf);
      drain("dual");
      complete_run();
   end
   // Watchdog, about half again the expected run with three loop settlings
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      miscompares++;
      complete_run();
   end
endmodule : tb
